// *** rtl/tdcop_decoder.sv ***
/*
 * Opcode decoder of the time-to-digital converter: holds the result,
 * status and calibration file, answers read opcodes, launches
 * measurements and performs the partial and full register resets.
 * Assumes the serial front end presents one opcode per transfer and
 * shifts out the answer, and that measurement engines write results.
 */
module tdcop_decoder
    import tdcop_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    input  wire tdcop_cmd_t        cmd,
    input  wire tdcop_wr_t         result_wr,
    input  wire logic [DATA_W-1:0] cfg0_wr_data,
    input  wire logic              cfg0_wr,
    output tdcop_rd_t              rd,
    output tdcop_ctl_t             ctl,
    output logic [DATA_W-1:0]      cfg0
);

    logic                rst_meta_r;
    logic                rst_sync_r;
    logic [DATA_W-1:0]   res_r [NUM_RES];
    logic [DATA_W-1:0]   res_nxt [NUM_RES];
    logic [DATA_W-1:0]   cfg0_r;
    logic [DATA_W-1:0]   cfg0_nxt;
    tdcop_rd_t           rd_r;
    tdcop_rd_t           rd_nxt;
    tdcop_ctl_t          ctl_r;
    tdcop_ctl_t          ctl_nxt;
    logic                rd_hit;
    logic [IDX_W-1:0]    rd_idx;

    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_r);

    // Map a read opcode to its result index; hit is low when not a read
    function automatic logic [IDX_W+1:0] read_map(input logic [7:0] op);
        logic [IDX_W+1:0] m;
        m = '0;
        if (op == OP_READ_UP_TOTAL)
            m = {2'b10, IDX_UP_TOTAL};
        else if (op >= OP_READ_DOWN_FIRST && op <= OP_READ_DOWN_LAST)
            m = {2'b10, IDX_DOWN_HIT0 + IDX_W'(op - OP_READ_DOWN_FIRST)};
        else if (op == OP_READ_DOWN_TOTAL)
            m = {2'b10, IDX_DOWN_TOTAL};
        else if (op >= OP_READ_TEMP_FIRST && op <= OP_READ_TEMP_LAST)
            m = {2'b10, IDX_TEMP0 + IDX_W'(op - OP_READ_TEMP_FIRST)};
        else if (op == OP_READ_WAVE_WIDTH)
            m = {2'b10, IDX_WAVE_WIDTH};
        else if (op == OP_READ_HIT_WIDTH)
            m = {2'b10, IDX_HIT_WIDTH};
        else if (op == OP_READ_STATUS)
            m = {2'b10, IDX_STATUS};
        else if (op == OP_READ_CAL)
            m = {2'b10, IDX_CAL};
        else if (op == OP_READ_COMM)
            m = {2'b11, IDX_W'(0)};
        return m;
    endfunction

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    logic [IDX_W+1:0] map_w;
    assign map_w  = read_map(cmd.code);
    assign rd_hit = cmd.valid && map_w[IDX_W+1];
    assign rd_idx = map_w[IDX_W-1:0];

    // Result file: engine writes, cleared by 0x70 and 0x50
    always_comb
    begin
        for (int i = 0; i < NUM_RES; i++)
            res_nxt[i] = res_r[i];
        if (result_wr.valid && result_wr.idx < IDX_W'(NUM_RES))
            res_nxt[result_wr.idx] = result_wr.data;
        if (cmd.valid && (cmd.code == OP_INIT_RESULTS ||
                          cmd.code == OP_SOFT_RESET))
        begin
            for (int i = 0; i < NUM_RES; i++)
                res_nxt[i] = RESULT_RST;
        end
    end

    // Configuration zero survives 0x70 but not 0x50
    always_comb
    begin
        cfg0_nxt = cfg0_r;
        if (cfg0_wr)
            cfg0_nxt = cfg0_wr_data;
        if (cmd.valid && cmd.code == OP_SOFT_RESET)
            cfg0_nxt = CFG0_RST;
    end

    always_comb
    begin
        rd_nxt = '0;
        if (rd_hit)
        begin
            rd_nxt.valid = 1'b1;
            if (map_w[IDX_W])
                rd_nxt.data = {{(DATA_W-8){1'b0}}, cfg0_r[7:0]};
            else
                rd_nxt.data = res_r[rd_idx];
        end
    end

    // Launch and clear requests are one-cycle pulses while clk_en stays high
    always_comb
    begin
        ctl_nxt = '{kind: TDCOP_START_NONE, clear_results: 1'b0,
                    clear_config: 1'b0};
        if (cmd.valid)
        begin
            case (cmd.code)
                OP_START_FLIGHT:     ctl_nxt.kind = TDCOP_START_FLIGHT;
                OP_START_BIDIR:      ctl_nxt.kind = TDCOP_START_BIDIR;
                OP_START_TEMP:       ctl_nxt.kind = TDCOP_START_TEMP;
                OP_START_TEMP_TWICE:
                    ctl_nxt.kind = TDCOP_START_TEMP_TWICE;
                OP_INIT_RESULTS:     ctl_nxt.clear_results = 1'b1;
                OP_SOFT_RESET:
                begin
                    ctl_nxt.clear_results = 1'b1;
                    ctl_nxt.clear_config  = 1'b1;
                end
                default:             ctl_nxt.kind = TDCOP_START_NONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            for (int i = 0; i < NUM_RES; i++)
                res_r[i] <= RESULT_RST;
            cfg0_r <= CFG0_RST;
            rd_r   <= '0;
            ctl_r  <= '{kind: TDCOP_START_NONE, clear_results: 1'b0,
                        clear_config: 1'b0};
        end
        else if (clk_en)
        begin
            res_r  <= res_nxt;
            cfg0_r <= cfg0_nxt;
            rd_r   <= rd_nxt;
            ctl_r  <= ctl_nxt;
        end
    end

    assign rd   = rd_r;
    assign ctl  = ctl_r;
    assign cfg0 = cfg0_r;

    a_init_keeps_cfg: assert property (
        clk_en && cmd.valid && cmd.code == OP_INIT_RESULTS && !cfg0_wr
        |=> cfg0_r == $past(cfg0_r) && res_r[IDX_STATUS] == RESULT_RST)
        else $error("init opcode disturbed configuration");
    a_init_clears_res: assert property (
        clk_en && cmd.valid && cmd.code == OP_INIT_RESULTS
        |=> res_r[IDX_DOWN_TOTAL] == RESULT_RST && ctl.clear_results
            && !ctl.clear_config)
        else $error("init opcode did not clear results");
    a_soft_reset_all: assert property (
        clk_en && cmd.valid && cmd.code == OP_SOFT_RESET
        |=> cfg0_r == CFG0_RST && ctl.clear_config)
        else $error("soft reset did not clear configuration");
    a_soft_clears_res: assert property (
        clk_en && cmd.valid && cmd.code == OP_SOFT_RESET
        |=> res_r[IDX_CAL] == RESULT_RST && ctl.clear_results)
        else $error("soft reset did not clear results");
    a_idle_no_clear: assert property (
        clk_en && !cmd.valid
        |=> !ctl.clear_results && !ctl.clear_config)
        else $error("clear request without an opcode");
    a_flight_start: assert property (
        clk_en && cmd.valid && cmd.code == OP_START_FLIGHT
        |=> ctl.kind == TDCOP_START_FLIGHT)
        else $error("flight start missing");
    a_flight_once: assert property (
        clk_en && cmd.valid && cmd.code == OP_START_FLIGHT
        ##1 clk_en && !cmd.valid
        |=> ctl.kind == TDCOP_START_NONE)
        else $error("flight start longer than one cycle");
    a_bidir_start: assert property (
        clk_en && cmd.valid && cmd.code == OP_START_BIDIR
        |=> ctl.kind == TDCOP_START_BIDIR)
        else $error("bidirectional start missing");
    a_temp_start: assert property (
        clk_en && cmd.valid && cmd.code == OP_START_TEMP
        |=> ctl.kind == TDCOP_START_TEMP)
        else $error("temperature start missing");
    a_temp_twice: assert property (
        clk_en && cmd.valid && cmd.code == OP_START_TEMP_TWICE
        |=> ctl.kind == TDCOP_START_TEMP_TWICE)
        else $error("double temperature start missing");
    a_down_hit_read: assert property (
        clk_en && cmd.valid && cmd.code == 8'hBA
        |=> rd.valid && rd.data == $past(res_r[1]))
        else $error("second down hit read wrong");
    a_last_hit_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_DOWN_LAST
        |=> rd.valid && rd.data == $past(res_r[IDX_DOWN_HIT0 + 5'h07]))
        else $error("eighth down hit read wrong");
    a_down_total_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_DOWN_TOTAL
        |=> rd.valid && rd.data == $past(res_r[IDX_DOWN_TOTAL]))
        else $error("down total read wrong");
    a_temp_one_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_TEMP_FIRST
        |=> rd.valid && rd.data == $past(res_r[IDX_TEMP0]))
        else $error("first temperature port read wrong");
    a_temp_four_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_TEMP_LAST
        |=> rd.valid && rd.data == $past(res_r[IDX_TEMP0 + 5'h03]))
        else $error("fourth temperature port read wrong");
    a_wave_width_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_WAVE_WIDTH
        |=> rd.valid && rd.data == $past(res_r[IDX_WAVE_WIDTH]))
        else $error("first wave width read wrong");
    a_hit_width_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_HIT_WIDTH
        |=> rd.valid && rd.data == $past(res_r[IDX_HIT_WIDTH]))
        else $error("first hit width read wrong");
    a_status_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_STATUS
        |=> rd.valid && rd.data == $past(res_r[IDX_STATUS]))
        else $error("status read wrong");
    a_comm_check: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_COMM
        |=> rd.data == {24'h000000, $past(cfg0_r[7:0])})
        else $error("comm check value wrong");
    a_comm_keeps_cfg: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_COMM && !cfg0_wr
        |=> rd.valid && cfg0_r == $past(cfg0_r))
        else $error("comm check disturbed configuration");
    a_cfg_write: assert property (
        clk_en && cfg0_wr && !cmd.valid
        |=> cfg0 == $past(cfg0_wr_data))
        else $error("configuration write lost");
    a_cal_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_CAL
        |=> rd.valid && rd.data == $past(res_r[IDX_CAL]))
        else $error("calibration read wrong");
    a_first_hit_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_DOWN_FIRST
        |=> rd.valid && rd.data == $past(res_r[IDX_DOWN_HIT0]))
        else $error("first down hit read wrong");
    a_up_total_read: assert property (
        clk_en && cmd.valid && cmd.code == OP_READ_UP_TOTAL
        |=> rd.valid && rd.data == $past(res_r[IDX_UP_TOTAL]))
        else $error("up total read wrong");
    a_unknown_quiet: assert property (
        clk_en && cmd.valid && cmd.code == 8'hFF
        |=> !rd.valid && ctl.kind == TDCOP_START_NONE)
        else $error("unknown opcode had an effect");
    a_unknown_two: assert property (
        clk_en && cmd.valid && cmd.code == 8'h02
        |=> !rd.valid && !ctl.clear_results && !ctl.clear_config)
        else $error("unknown opcode raised an output");
    a_unknown_keeps: assert property (
        clk_en && cmd.valid && cmd.code == 8'h02
        && !cfg0_wr && !result_wr.valid
        |=> cfg0_r == $past(cfg0_r) && res_r[0] == $past(res_r[0]))
        else $error("unknown opcode changed a register");
    a_idle_no_answer: assert property (
        clk_en && !cmd.valid
        |=> !rd.valid && ctl.kind == TDCOP_START_NONE)
        else $error("answer without an opcode");
    a_engine_write: assert property (
        clk_en && result_wr.valid && result_wr.idx == IDX_CAL && !cmd.valid
        |=> res_r[IDX_CAL] == $past(result_wr.data))
        else $error("engine result write lost");
    a_freeze_holds: assert property (
        !clk_en
        |=> rd == $past(rd) && ctl == $past(ctl) && cfg0 == $past(cfg0))
        else $error("state moved while clock enable low");

endmodule

// *** rtl/tdcop_pkg.sv ***
/*
 * Package for the opcode decoder of the time-to-digital converter.
 * Holds opcode values, result-file indices, reset values and carriers.
 * Assumes the serial front end delivers whole opcode bytes.
 */
package tdcop_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_RES = 19;
    localparam int unsigned IDX_W = 5;

    // Opcodes
    localparam logic [7:0] OP_READ_UP_TOTAL   = 8'hB8;
    localparam logic [7:0] OP_READ_DOWN_FIRST = 8'hB9;
    localparam logic [7:0] OP_READ_DOWN_LAST  = 8'hC0;
    localparam logic [7:0] OP_READ_DOWN_TOTAL = 8'hC1;
    localparam logic [7:0] OP_READ_TEMP_FIRST = 8'hC2;
    localparam logic [7:0] OP_READ_TEMP_LAST  = 8'hC5;
    localparam logic [7:0] OP_READ_WAVE_WIDTH = 8'hD0;
    localparam logic [7:0] OP_READ_HIT_WIDTH  = 8'hD1;
    localparam logic [7:0] OP_READ_STATUS     = 8'hD2;
    localparam logic [7:0] OP_READ_COMM       = 8'hD3;
    localparam logic [7:0] OP_READ_CAL        = 8'hD4;
    localparam logic [7:0] OP_INIT_RESULTS    = 8'h70;
    localparam logic [7:0] OP_SOFT_RESET      = 8'h50;
    localparam logic [7:0] OP_START_FLIGHT    = 8'h01;
    localparam logic [7:0] OP_START_BIDIR     = 8'h03;
    localparam logic [7:0] OP_START_TEMP      = 8'h04;
    localparam logic [7:0] OP_START_TEMP_TWICE = 8'h05;

    // Result file indices: 0..7 down hits, 8 down total, 9 up total,
    // 10..13 temperature ports, 14 wave width, 15 hit width, 16 status,
    // 17 calibration, 18 spare
    localparam logic [IDX_W-1:0] IDX_DOWN_HIT0   = 5'h00;
    localparam logic [IDX_W-1:0] IDX_DOWN_TOTAL  = 5'h08;
    localparam logic [IDX_W-1:0] IDX_UP_TOTAL    = 5'h09;
    localparam logic [IDX_W-1:0] IDX_TEMP0       = 5'h0A;
    localparam logic [IDX_W-1:0] IDX_WAVE_WIDTH  = 5'h0E;
    localparam logic [IDX_W-1:0] IDX_HIT_WIDTH   = 5'h0F;
    localparam logic [IDX_W-1:0] IDX_STATUS      = 5'h10;
    localparam logic [IDX_W-1:0] IDX_CAL         = 5'h11;

    localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CFG0_RST   = 32'h0000_0000;

    typedef enum logic [2:0] {
        TDCOP_START_NONE,
        TDCOP_START_FLIGHT,
        TDCOP_START_BIDIR,
        TDCOP_START_TEMP,
        TDCOP_START_TEMP_TWICE
    } tdcop_start_t;

    // Opcode from the serial front end
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } tdcop_cmd_t;

    // Result written back by a measurement engine
    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  idx;
        logic [DATA_W-1:0] data;
    } tdcop_wr_t;

    // Read answer to the serial front end
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } tdcop_rd_t;

    // Measurement launch and register reset requests
    typedef struct packed {
        tdcop_start_t kind;
        logic         clear_results;
        logic         clear_config;
    } tdcop_ctl_t;

endpackage

// *** test/tdcop_host.sv ***
/*
 * Host model on the opcode port of the decoder.
 * Assumes the bench calls send and samples the answer itself.
 */
module tdcop_host
    import tdcop_pkg::*;
(
    input  wire logic clk,
    output tdcop_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd = '{1'b0, 8'hFF};

    // Released code lines show the inverse, so a stale opcode never matches
    task automatic send(input logic [7:0] code);
        @(posedge clk);
        cmd <= '{1'b1, code};
        @(posedge clk);
        cmd <= '{1'b0, ~code};
    endtask
endmodule

// *** test/tdc_opcode_decoder_tb.sv ***
/*
 * Bench for the opcode decoder: reads, resets, launches, unknown code.
 * Assumes tdcop_host drives the opcode port; the bench acts as engines.
 */
module tdc_opcode_decoder_tb
    import tdcop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    tdcop_cmd_t        cmd;
    tdcop_wr_t         wr = '0;
    logic [DATA_W-1:0] cfg_d = 32'h0;
    logic              cfg_we = 1'b0;
    logic              en = 1'b1;
    tdcop_rd_t         rd;
    tdcop_ctl_t        ctl;
    logic [DATA_W-1:0] cfg0;
    int                err_count = 0;
    int                total_checks = 0;

    always #5 clk = ~clk;

    tdcop_host h (.clk(clk), .cmd(cmd));

    tdcop_decoder dut (.clk(clk), .rst_b(rst_b), .clk_en(en),
        .cmd(cmd), .result_wr(wr), .cfg0_wr_data(cfg_d),
        .cfg0_wr(cfg_we), .rd(rd), .ctl(ctl), .cfg0(cfg0));

    function automatic logic [DATA_W-1:0] val(input logic [IDX_W-1:0] i);
        return {24'hA5A500, 3'h0, i};
    endfunction

    task automatic chk(input string n, input logic [DATA_W-1:0] e,
                       input logic [DATA_W-1:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic rdop(input logic [7:0] op, input logic [DATA_W-1:0] e);
        h.send(op);
        #1;
        chk("rd.valid", 32'h1, {31'h0, rd.valid});
        chk("rd.data", e, rd.data);
        @(posedge clk);
        #1;
        chk("rd.valid after", 32'h0, {31'h0, rd.valid});
    endtask

    task automatic wres(input logic [IDX_W-1:0] i,
                        input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr <= '{1'b1, i, d};
        @(posedge clk);
        wr <= '{1'b0, i, ~d};
    endtask

    task automatic t_reads;
        rdop(8'hB9, 32'h0);
        for (int i = 0; i < 18; i++)
            wres(i[IDX_W-1:0], val(i[IDX_W-1:0]));
        rdop(8'hB9, val(5'h00));
        for (int i = 1; i < 8; i++)
            rdop(8'hB9 + i[7:0], val(i[IDX_W-1:0]));
        rdop(8'hC1, val(5'h08));
        rdop(8'hB8, val(5'h09));
        for (int i = 0; i < 4; i++)
            rdop(8'hC2 + i[7:0], val(5'h0A + i[IDX_W-1:0]));
        rdop(8'hD0, val(5'h0E));
        rdop(8'hD1, val(5'h0F));
        rdop(8'hD2, val(5'h10));
        rdop(8'hD4, val(5'h11));
        $display("test reads done");
    endtask

    task automatic t_comm;
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_d <= 32'h1234_56C3;
        @(posedge clk);
        cfg_we <= 1'b0;
        rdop(8'hD3, 32'h0000_00C3);
        $display("test comm done");
    endtask

    task automatic t_init;
        h.send(8'h70);
        #1;
        chk("clear_results", 32'h1, {31'h0, ctl.clear_results});
        chk("clear_config", 32'h0, {31'h0, ctl.clear_config});
        chk("cfg0", 32'h1234_56C3, cfg0);
        rdop(8'hD2, 32'h0);
        rdop(8'hC1, 32'h0);
        rdop(8'hD3, 32'h0000_00C3);
        $display("test init done");
    endtask

    task automatic t_unknown;
        wres(5'h00, 32'h0000_0BAD);
        h.send(8'h02);
        #1;
        chk("rd.valid", 32'h0, {31'h0, rd.valid});
        chk("kind", 32'h0, {29'h0, ctl.kind});
        h.send(8'hFF);
        #1;
        chk("rd.valid", 32'h0, {31'h0, rd.valid});
        chk("kind", 32'h0, {29'h0, ctl.kind});
        rdop(8'hB9, 32'h0000_0BAD);
        $display("test unknown done");
    endtask

    task automatic t_start;
        logic [7:0]   ops [4] = '{8'h01, 8'h03, 8'h04, 8'h05};
        tdcop_start_t ks [4] = '{TDCOP_START_FLIGHT, TDCOP_START_BIDIR,
                                 TDCOP_START_TEMP, TDCOP_START_TEMP_TWICE};
        for (int i = 0; i < 4; i++)
        begin
            h.send(ops[i]);
            #1;
            chk("kind", {29'h0, ks[i]}, {29'h0, ctl.kind});
        end
        $display("test start done");
    endtask

    task automatic t_por;
        wres(5'h11, 32'h0000_7777);
        h.send(8'h50);
        #1;
        chk("clear_config", 32'h1, {31'h0, ctl.clear_config});
        chk("clear_results", 32'h1, {31'h0, ctl.clear_results});
        chk("cfg0", 32'h0, cfg0);
        rdop(8'hD4, 32'h0);
        rdop(8'hD3, 32'h0);
        $display("test por done");
    endtask

    // An opcode offered while the enable is low must be lost
    task automatic t_freeze;
        @(posedge clk);
        en <= 1'b0;
        h.send(8'h01);
        #1;
        chk("kind frozen", 32'h0, {29'h0, ctl.kind});
        @(posedge clk);
        en <= 1'b1;
        h.send(8'h01);
        #1;
        chk("kind", {29'h0, TDCOP_START_FLIGHT}, {29'h0, ctl.kind});
        $display("test freeze done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reads;
        t_comm;
        t_init;
        t_unknown;
        t_start;
        t_por;
        t_freeze;
        conclude;
    end

    // A hang counts as a mismatch
    initial
    begin
        #200000;
        err_count++;
        conclude;
    end
endmodule
